// *** rtl/oass_pkg.sv ***
// constants, carriers and shared decode for the operand/address size select
// assumes a single core clock and a synchronous active-low core reset
`default_nettype none
package oass_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_ICOUNT    = 8'h08;

  // control register field positions
  localparam int          CTRL_CODE_D    = 0;
  localparam int          CTRL_STACK_B   = 1;
  localparam int          CTRL_MODE      = 2;
  localparam int          CTRL_DATA_B    = 4;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK     = 32'h0000_001F;
  localparam logic [31:0] ICOUNT_RST     = 32'h0000_0000;

  localparam logic [7:0]  PFX_OPSIZE     = 8'h66;
  localparam logic [7:0]  PFX_ADSIZE     = 8'h67;

  localparam logic [31:0] OFS_MASK_16    = 32'h0000_FFFF;
  localparam logic [31:0] OFS_MASK_32    = 32'hFFFF_FFFF;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    MODE_PROT,
    MODE_REAL,
    MODE_V86,
    MODE_RSVD
  } oass_mode_t;

  typedef enum logic {
    DEC_IDLE,
    DEC_PREFIX
  } oass_dec_t;

  // sizes decided for one instruction
  typedef struct packed {
    logic        op32;
    logic        adr32;
    logic        stk32;
    logic        frame32;
    logic [31:0] ofs_mask;
  } oass_sizes_t;

  typedef struct packed {
    logic        valid;
    oass_sizes_t sz;
  } oass_sel_st_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] icount;
    oass_dec_t   dec;
    logic        op_pfx;
    logic        adr_pfx;
    logic        op_ovr;
    logic        adr_ovr;
    logic        start;
    logic        gate;
    logic        gate32;
    logic [31:0] ed_limit;
  } oass_top_st_t;

  // segment default width: descriptor flag only counts in protected mode
  function automatic logic default_wide(input oass_mode_t mode,
                                        input logic       flag);
    return (mode == MODE_PROT) && flag;
  endfunction

endpackage
`default_nettype wire

// *** rtl/oass_size_sel.sv ***
// per-instruction size resolver: registers the sizes of one instruction
// assumes start is a one-cycle pulse on the opcode byte, same clock
`timescale 1ns/1ps
`default_nettype none
module oass_size_sel (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               start_i,
  input  wire oass_pkg::oass_mode_t mode_i,
  input  wire logic               code_d_i,
  input  wire logic               stack_b_i,
  input  wire logic               op_pfx_i,
  input  wire logic               adr_pfx_i,
  input  wire logic               gate_i,
  input  wire logic               gate32_i,
  output logic                    valid_o,
  output oass_pkg::oass_sizes_t   sizes_o
);

  oass_pkg::oass_sel_st_t st_reg;
  oass_pkg::oass_sel_st_t st_next;

  always_comb begin
    logic dflt;
    logic stk;
    dflt    = oass_pkg::default_wide(mode_i, code_d_i);
    stk     = oass_pkg::default_wide(mode_i, stack_b_i);
    st_next = st_reg;
    st_next.valid = start_i;
    if (start_i) begin
      // operand and address width are each the default turned round by its own prefix
      st_next.sz.op32  = dflt ^ op_pfx_i;
      st_next.sz.adr32 = dflt ^ adr_pfx_i;
      st_next.sz.stk32 = stk;
      st_next.sz.frame32 = st_next.sz.op32;
      if (gate_i) begin
        // a gate fixes the transfer width, prefixes do not reach it
        st_next.sz.op32    = gate32_i;
        st_next.sz.stk32   = gate32_i;
        st_next.sz.frame32 = gate32_i;
      end
      st_next.sz.ofs_mask = st_next.sz.adr32 ? oass_pkg::OFS_MASK_32
                                             : oass_pkg::OFS_MASK_16;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign valid_o = st_reg.valid;
  assign sizes_o = st_reg.sz;

endmodule
`default_nettype wire

// *** rtl/oass_top.sv ***
// operand/address size select with an AXI4-Lite control slave
// assumes the instruction byte stream comes from fetch logic on CLOCK_I
//
// Operation
// - code segment flag set gives 32-bit default operand and address size
// - real-address and virtual-8086 modes default both sizes to 16 bits
// - operand-size prefix inverts the default operand size
// - address-size prefix inverts the default address size, independently
// - a prefix override lasts for the following instruction only
// - both prefixes work in protected, real and virtual-8086 modes
// - operand and address size derived separately; all four combinations
// - stack flag picks wide or narrow stack pointer for implicit references
// - explicit stack data accesses use the instruction's address size
// - data segment width flag sets expand-down upper address bound
// - gate type sets operand, stack pointer and return frame width
// - 16-bit addressing reaches only the first 64 KBytes of a segment
// - selected width sets operand, result and address calculation width
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module oass_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        INSN_BYTE_VALID_I,
  input  wire logic [7:0]  INSN_BYTE_I,
  input  wire logic        GATE_XFER_I,
  input  wire logic        GATE_32_I,
  output logic             SIZE_VALID_O,
  output logic             OPERAND_32_O,
  output logic             ADDRESS_32_O,
  output logic             WIDE_STACK_POINTER_O,
  output logic             FRAME_32_O,
  output logic [31:0]      OFFSET_MASK_O,
  output logic [31:0]      EXPDOWN_LIMIT_O
);

  oass_pkg::oass_top_st_t st_reg;
  oass_pkg::oass_top_st_t st_next;
  oass_pkg::oass_sizes_t  sizes;
  logic                   sizes_valid;
  oass_pkg::oass_mode_t   mode;
  logic                   code_d;
  logic                   stack_b;
  logic                   data_b;
  logic                   dflt32;

  // any prefix byte keeps the instruction open; only 66/67 change sizes
  function automatic logic is_prefix(input logic [7:0] b);
    case (b)
      8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65,
      8'hF0, 8'hF2, 8'hF3, oass_pkg::PFX_OPSIZE,
      oass_pkg::PFX_ADSIZE: is_prefix = 1'b1;
      default: is_prefix = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign mode    = oass_pkg::oass_mode_t'(
                     st_reg.ctrl[oass_pkg::CTRL_MODE +: 2]);
  assign code_d  = st_reg.ctrl[oass_pkg::CTRL_CODE_D];
  assign stack_b = st_reg.ctrl[oass_pkg::CTRL_STACK_B];
  assign data_b  = st_reg.ctrl[oass_pkg::CTRL_DATA_B];
  assign dflt32  = oass_pkg::default_wide(mode, code_d);

  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;

    // write address and data are caught in either order
    if (S_AXI_AWVALID_I && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = S_AXI_WDATA_I;
      st_next.wstrb = S_AXI_WSTRB_I;
    end
    if (st_reg.bvalid && S_AXI_BREADY_I) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = oass_pkg::RESP_OKAY;
      case (st_reg.awaddr)
        oass_pkg::ADDR_CTRL: begin
          st_next.ctrl = merge_lanes(st_reg.ctrl, st_reg.wdata,
                                     st_reg.wstrb) & oass_pkg::CTRL_WMASK;
        end
        oass_pkg::ADDR_STATUS, oass_pkg::ADDR_ICOUNT: begin
          st_next.bresp = oass_pkg::RESP_OKAY;
        end
        default: begin
          st_next.bresp = oass_pkg::RESP_SLVERR;
        end
      endcase
    end
    // ready held low while a word waits or the response is pending
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready  = !st_next.w_got && !st_next.bvalid;

    if (st_reg.rvalid && S_AXI_RREADY_I) begin
      st_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = oass_pkg::RESP_OKAY;
      case (S_AXI_ARADDR_I)
        oass_pkg::ADDR_CTRL: begin
          st_next.rdata = st_reg.ctrl;
        end
        oass_pkg::ADDR_STATUS: begin
          st_next.rdata = {25'h0, st_reg.dec == oass_pkg::DEC_PREFIX,
                           dflt32, sizes.frame32, sizes.stk32,
                           sizes.adr32, sizes.op32, sizes_valid};
        end
        oass_pkg::ADDR_ICOUNT: begin
          st_next.rdata = st_reg.icount;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = oass_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // prefix tracking: repeats just set the same flag again
    if (INSN_BYTE_VALID_I) begin
      if (is_prefix(INSN_BYTE_I)) begin
        st_next.dec = oass_pkg::DEC_PREFIX;
        if (INSN_BYTE_I == oass_pkg::PFX_OPSIZE) begin
          st_next.op_pfx = 1'b1;
        end
        if (INSN_BYTE_I == oass_pkg::PFX_ADSIZE) begin
          st_next.adr_pfx = 1'b1;
        end
      end else begin
        // opcode byte closes the instruction; overrides end with it
        st_next.start   = 1'b1;
        st_next.gate    = GATE_XFER_I;
        st_next.gate32  = GATE_32_I;
        st_next.dec     = oass_pkg::DEC_IDLE;
        st_next.op_pfx  = 1'b0;
        st_next.op_ovr  = st_reg.op_pfx;
        st_next.adr_ovr = st_reg.adr_pfx;
        st_next.adr_pfx = 1'b0;
        st_next.icount  = st_reg.icount + 32'h0000_0001;
      end
    end

    // expand-down bound follows the data segment width flag
    st_next.ed_limit = data_b ? oass_pkg::OFS_MASK_32
                              : oass_pkg::OFS_MASK_16;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      st_reg        <= '0;
      st_reg.ctrl   <= oass_pkg::CTRL_RST;
      st_reg.icount <= oass_pkg::ICOUNT_RST;
      st_reg.dec    <= oass_pkg::DEC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // overrides are caught with the opcode so its own prefixes still count
  logic op_pfx_q;
  logic adr_pfx_q;
  assign op_pfx_q  = st_reg.op_ovr;
  assign adr_pfx_q = st_reg.adr_ovr;

  oass_size_sel u_size_sel (
    .clk_i     (CLOCK_I),
    .rst_n_i   (RST_N_I),
    .start_i   (st_reg.start),
    .mode_i    (mode),
    .code_d_i  (code_d),
    .stack_b_i (stack_b),
    .op_pfx_i  (op_pfx_q),
    .adr_pfx_i (adr_pfx_q),
    .gate_i    (st_reg.gate),
    .gate32_i  (st_reg.gate32),
    .valid_o   (sizes_valid),
    .sizes_o   (sizes)
  );

  assign S_AXI_AWREADY_O      = st_reg.awready;
  assign S_AXI_WREADY_O       = st_reg.wready;
  assign S_AXI_BVALID_O       = st_reg.bvalid;
  assign S_AXI_BRESP_O        = st_reg.bresp;
  assign S_AXI_ARREADY_O      = st_reg.arready;
  assign S_AXI_RVALID_O       = st_reg.rvalid;
  assign S_AXI_RRESP_O        = st_reg.rresp;
  assign S_AXI_RDATA_O        = st_reg.rdata;
  assign SIZE_VALID_O         = sizes_valid;
  assign OPERAND_32_O         = sizes.op32;
  assign ADDRESS_32_O         = sizes.adr32;
  assign WIDE_STACK_POINTER_O = sizes.stk32;
  assign FRAME_32_O           = sizes.frame32;
  assign OFFSET_MASK_O        = sizes.ofs_mask;
  assign EXPDOWN_LIMIT_O      = st_reg.ed_limit;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  AST_DFLAG_DEFAULT: assert property (
    st_reg.start && !st_reg.gate && !op_pfx_q && mode == oass_pkg::MODE_PROT
    |=> OPERAND_32_O == $past(code_d) && SIZE_VALID_O)
    else $error("operand size does not follow segment default");

  AST_REAL_V86_16: assert property (
    st_reg.start && !st_reg.gate && !op_pfx_q && !adr_pfx_q &&
    (mode == oass_pkg::MODE_REAL || mode == oass_pkg::MODE_V86)
    |=> !OPERAND_32_O && !ADDRESS_32_O)
    else $error("real or v86 default is not 16 bits");

  AST_OPSZ_INVERT: assert property (
    INSN_BYTE_VALID_I && INSN_BYTE_I == oass_pkg::PFX_OPSIZE ##1
    INSN_BYTE_VALID_I && !is_prefix(INSN_BYTE_I) && !GATE_XFER_I
    ##2 1'b1 |-> OPERAND_32_O != $past(dflt32, 2))
    else $error("operand prefix did not invert size");

  AST_ADSZ_INVERT: assert property (
    st_reg.start && adr_pfx_q |=> ADDRESS_32_O == !$past(dflt32))
    else $error("address prefix did not invert size");

  AST_ONE_INSN: assert property (
    INSN_BYTE_VALID_I && !is_prefix(INSN_BYTE_I)
    |=> !st_reg.op_pfx && !st_reg.adr_pfx && st_reg.start)
    else $error("prefix override outlived its instruction");

  AST_STACK_WIDTH: assert property (
    st_reg.start && !st_reg.gate
    |=> WIDE_STACK_POINTER_O ==
        $past(stack_b && mode == oass_pkg::MODE_PROT))
    else $error("stack pointer width not from stack flag");

  AST_EXPDOWN: assert property (
    data_b |=> EXPDOWN_LIMIT_O == oass_pkg::OFS_MASK_32)
    else $error("expand-down bound wrong");

  AST_GATE_SIZE: assert property (
    st_reg.start && st_reg.gate
    |=> OPERAND_32_O == $past(st_reg.gate32) &&
        FRAME_32_O == $past(st_reg.gate32) &&
        WIDE_STACK_POINTER_O == $past(st_reg.gate32))
    else $error("gate transfer width not from gate type");

  AST_OFS_MASK: assert property (
    SIZE_VALID_O && !ADDRESS_32_O |-> OFFSET_MASK_O == oass_pkg::OFS_MASK_16)
    else $error("16-bit addressing exceeds 64 KBytes");

  AST_PFX_ONCE: assert property (
    st_reg.op_pfx && INSN_BYTE_VALID_I && INSN_BYTE_I == oass_pkg::PFX_OPSIZE
    |=> st_reg.op_pfx)
    else $error("repeated prefix cancelled the override");

  AST_V86_STACK: assert property (
    st_reg.start && !st_reg.gate && mode != oass_pkg::MODE_PROT
    |=> !WIDE_STACK_POINTER_O)
    else $error("narrow stack pointer expected outside protected mode");

  AST_OPSZ_KEEP: assert property (
    st_reg.start && !st_reg.gate && op_pfx_q
    |=> OPERAND_32_O == !$past(dflt32))
    else $error("operand prefix did not reverse default");

  AST_SIZE_PULSE: assert property (
    st_reg.start |=> SIZE_VALID_O)
    else $error("sizes not produced for opcode");

  AST_NO_SPURIOUS: assert property (
    !st_reg.start |=> !SIZE_VALID_O)
    else $error("size pulse without opcode");

  AST_ADR_INDEP: assert property (
    st_reg.start && !adr_pfx_q |=> ADDRESS_32_O == $past(dflt32))
    else $error("address size not from segment default");

  AST_EXPDOWN_16: assert property (
    !data_b |=> EXPDOWN_LIMIT_O == oass_pkg::OFS_MASK_16)
    else $error("expand-down bound not 64 KBytes");

  AST_MASK_32: assert property (
    SIZE_VALID_O && ADDRESS_32_O |-> OFFSET_MASK_O == oass_pkg::OFS_MASK_32)
    else $error("32-bit addressing offset mask wrong");

  AST_FRAME_OP: assert property (
    st_reg.start && !st_reg.gate |=> FRAME_32_O == OPERAND_32_O)
    else $error("return frame width differs from operand size");

  AST_PFX_ONCE_ADR: assert property (
    st_reg.adr_pfx && INSN_BYTE_VALID_I &&
    INSN_BYTE_I == oass_pkg::PFX_ADSIZE
    |=> st_reg.adr_pfx)
    else $error("repeated address prefix cancelled the override");

  COV_BOTH_PFX: cover property (
    st_reg.start && op_pfx_q && adr_pfx_q && !dflt32);
  COV_GATE32: cover property (st_reg.start && st_reg.gate && st_reg.gate32);
  COV_WRITE: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  COV_BAD_READ: cover property (
    S_AXI_RVALID_O && S_AXI_RRESP_O == oass_pkg::RESP_SLVERR);

endmodule
`default_nettype wire

// *** testbench/oass_top_tb.sv ***
// self-checking bench for the operand/address size select block
// assumes oass_pkg and oass_top compiled first; drives all ports itself
`timescale 1ns/1ps
`default_nettype none
module oass_top_tb;
  logic        CLOCK_I = 1'b0;
  logic        RST_N_I = 1'b0;
  logic [7:0]  S_AXI_AWADDR_I = 8'h00;
  logic        S_AXI_AWVALID_I = 1'b0;
  logic [31:0] S_AXI_WDATA_I = 32'h0;
  logic [3:0]  S_AXI_WSTRB_I = 4'hF;
  logic        S_AXI_WVALID_I = 1'b0;
  logic        S_AXI_BREADY_I = 1'b0;
  logic [7:0]  S_AXI_ARADDR_I = 8'h00;
  logic        S_AXI_ARVALID_I = 1'b0;
  logic        S_AXI_RREADY_I = 1'b0;
  logic        INSN_BYTE_VALID_I = 1'b0;
  logic [7:0]  INSN_BYTE_I = 8'h00;
  logic        GATE_XFER_I = 1'b0;
  logic        GATE_32_I = 1'b0;
  logic        S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
  logic        S_AXI_ARREADY_O, S_AXI_RVALID_O, SIZE_VALID_O;
  logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [31:0] S_AXI_RDATA_O, OFFSET_MASK_O, EXPDOWN_LIMIT_O;
  logic        OPERAND_32_O, ADDRESS_32_O, WIDE_STACK_POINTER_O, FRAME_32_O;
  logic [35:0] exp_q[$];
  logic [31:0] ctrl_m = 32'h0;
  logic [31:0] stat_m = 32'h0;
  logic [7:0]  segp[9] = '{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65, 8'hF0,
                           8'hF2, 8'hF3};
  logic [7:0]  opc[4] = '{8'h8B, 8'h89, 8'hE8, 8'h50};
  int          errors = 0;
  int          num_checks = 0;
  int          sent = 0;

  oass_top uut (
    .CLOCK_I, .RST_N_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
    .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
    .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I,
    .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
    .S_AXI_RVALID_O, .S_AXI_RREADY_I, .INSN_BYTE_VALID_I, .INSN_BYTE_I,
    .GATE_XFER_I, .GATE_32_I, .SIZE_VALID_O, .OPERAND_32_O, .ADDRESS_32_O,
    .WIDE_STACK_POINTER_O, .FRAME_32_O, .OFFSET_MASK_O, .EXPDOWN_LIMIT_O
  );

  always #12.5 CLOCK_I = ~CLOCK_I;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tmo;
    errors++;
    $display("wrong value handshake expected answer seen none");
    wrap_up;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge CLOCK_I);
    S_AXI_AWADDR_I  <= a;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WDATA_I   <= d;
    S_AXI_WVALID_I  <= 1'b1;
    S_AXI_BREADY_I  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK_I);
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
      if (S_AXI_BVALID_O === 1'b1) begin
        r = S_AXI_BRESP_O;
        S_AXI_BREADY_I <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge CLOCK_I);
    S_AXI_ARADDR_I  <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK_I);
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
      if (S_AXI_RVALID_O === 1'b1) begin
        d = S_AXI_RDATA_O;
        r = S_AXI_RRESP_O;
        S_AXI_RREADY_I <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo;
  endtask

  // upper ctrl bits get random junk: they must read back as zero
  task automatic set_ctrl(input logic [4:0] f);
    logic [31:0] v;
    logic [31:0] d;
    logic [1:0]  r;
    v = ($urandom & 32'hFFFF_FFE0) | {27'h0, f};
    axi_wr(oass_pkg::ADDR_CTRL, v, r);
    chk("ctrl bresp", {30'h0, oass_pkg::RESP_OKAY}, {30'h0, r});
    ctrl_m = v & oass_pkg::CTRL_WMASK;
    axi_rd(oass_pkg::ADDR_CTRL, d, r);
    chk("ctrl read", ctrl_m, d);
    repeat (2) @(posedge CLOCK_I);
    chk("expdown", ctrl_m[4] ? 32'hFFFF_FFFF : 32'h0000_FFFF,
        EXPDOWN_LIMIT_O);
  endtask

  task automatic put(input logic [7:0] b, input logic g, input logic g32);
    @(posedge CLOCK_I);
    INSN_BYTE_VALID_I <= 1'b1;
    INSN_BYTE_I       <= b;
    GATE_XFER_I       <= g;
    GATE_32_I         <= g32;
  endtask

  // expected sizes are queued before the opcode byte goes out
  task automatic insn(input int nop, input int nad, input logic g,
                      input logic g32);
    logic d, o, a, s;
    d = (ctrl_m[3:2] == 2'b00) && ctrl_m[0];
    s = g ? g32 : ((ctrl_m[3:2] == 2'b00) && ctrl_m[1]);
    o = g ? g32 : (d ^ (nop > 0));
    a = d ^ (nad > 0);
    for (int k = 0; k < nop; k++) begin
      put(segp[$urandom % 9], 1'b0, 1'b0);
      put(oass_pkg::PFX_OPSIZE, 1'b0, 1'b0);
    end
    for (int k = 0; k < nad; k++) put(oass_pkg::PFX_ADSIZE, 1'b0, 1'b0);
    exp_q.push_back({o, a, s, o, a ? 32'hFFFF_FFFF : 32'h0000_FFFF});
    stat_m = {25'h0, 1'b0, d, o, s, a, o, 1'b0};
    put(opc[$urandom % 4], g, g32);
    sent++;
  endtask

  task automatic drain;
    int n;
    @(posedge CLOCK_I);
    INSN_BYTE_VALID_I <= 1'b0;
    GATE_XFER_I       <= 1'b0;
    for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge CLOCK_I);
    if (exp_q.size() != 0) tmo;
  endtask

  // every size pulse is matched against the oldest queued expectation
  always @(posedge CLOCK_I) begin
    logic [35:0] e;
    if (RST_N_I === 1'b1 && SIZE_VALID_O !== 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("wrong value size_valid expected 0 seen %b", SIZE_VALID_O);
      end else begin
        e = exp_q.pop_front();
        chk("op32", {31'h0, e[35]}, {31'h0, OPERAND_32_O});
        chk("adr32", {31'h0, e[34]}, {31'h0, ADDRESS_32_O});
        chk("stk32", {31'h0, e[33]}, {31'h0, WIDE_STACK_POINTER_O});
        chk("frame32", {31'h0, e[32]}, {31'h0, FRAME_32_O});
        chk("ofs mask", e[31:0], OFFSET_MASK_O);
      end
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    void'($urandom(32'hbe2284f9));
    repeat (12) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    axi_rd(oass_pkg::ADDR_CTRL, d, r);
    chk("ctrl reset", oass_pkg::CTRL_RST, d);
    axi_rd(oass_pkg::ADDR_ICOUNT, d, r);
    chk("icount reset", oass_pkg::ICOUNT_RST, d);
    axi_rd(8'h0C, d, r);
    chk("unmapped rresp", {30'h0, oass_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    axi_wr(8'h10, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", {30'h0, oass_pkg::RESP_SLVERR}, {30'h0, r});
    S_AXI_WSTRB_I <= 4'h1;
    axi_wr(oass_pkg::ADDR_CTRL, 32'hFFFF_FF15, r);
    axi_rd(oass_pkg::ADDR_CTRL, d, r);
    chk("ctrl lane0", 32'h0000_0015, d);
    S_AXI_WSTRB_I <= 4'hE;
    axi_wr(oass_pkg::ADDR_CTRL, 32'hFFFF_FF00, r);
    axi_rd(oass_pkg::ADDR_CTRL, d, r);
    chk("ctrl lanes off", 32'h0000_0015, d);
    S_AXI_WSTRB_I <= 4'hF;
    $display("test registers done");
    // mode, stack flag and code flag swept; prefix counts 0..2 each
    for (int m = 0; m < 16; m++) begin
      set_ctrl({1'($urandom), m[3:0]});
      for (int p = 0; p < 3; p++)
        for (int q = 0; q < 3; q++) insn(p, q, 1'b0, 1'b0);
      for (int k = 0; k < 4; k++)
        insn($urandom % 2, $urandom % 2, 1'b1, k[0]);
      drain;
      axi_wr(oass_pkg::ADDR_STATUS, $urandom, r);
      chk("status bresp", {30'h0, oass_pkg::RESP_OKAY}, {30'h0, r});
      axi_rd(oass_pkg::ADDR_STATUS, d, r);
      chk("status", stat_m, d);
      $display("test sizes ctrl %h done", ctrl_m);
    end
    axi_rd(oass_pkg::ADDR_ICOUNT, d, r);
    chk("icount", sent, d);
    $display("test count done");
    wrap_up;
  end
endmodule
`default_nettype wire
